// File: hw/ppdc_pkg.sv
// Constants shared by the printer port direction block
package ppdc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_DATA      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_CONTROL   = 8'h08;
    localparam logic [7:0] OFF_MODE      = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;

    // Control register fields
    localparam int CTRL_IRQ_EN_BIT = 4;
    localparam int CTRL_DIR_BIT    = 5;

    // Mode register fields
    localparam int MODE_LINE_SEL_BIT = 0;
    localparam int MODE_DIR_STRAP_BIT = 1;
    localparam int MODE_EXT_BIT      = 7;

    // Status register fields
    localparam int STAT_PAPER_OUT_BIT = 0;
    localparam int STAT_DONE_BIT      = 1;
    localparam int STAT_DIR_IN_BIT    = 2;

    // Interrupt event bits
    localparam int EVT_PAPER_OUT = 0;
    localparam int EVT_DONE      = 1;
    localparam int EVT_W         = 2;

    // Values after reset
    localparam logic [7:0]       RST_DATA      = 8'h00;
    localparam logic [7:0]       RST_CONTROL   = 8'h00;
    localparam logic [EVT_W-1:0] RST_IRQ       = 2'h0;
    localparam logic             RST_EXT       = 1'b0;
    localparam logic             RST_DIR_STRAP = 1'b1;

    // Bus data phase states
    typedef enum logic [3:0] {
        BUS_IDLE  = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_RWAIT = 4'b0100,
        BUS_RDONE = 4'b1000
    } ppdc_bus_e;

endpackage

// File: hw/ppdc_strap.sv
// Strap capture for mode and direction straps after reset release
`timescale 1ns/1ps
module ppdc_strap
    import ppdc_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic mode_strap_pin,
    input  wire logic direction_strap_pin,
    output logic      extended_mode_bit,
    output logic      dir_strap,
    output logic      captured
);

    // First edge after release takes the pins once; afterwards they hold
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            extended_mode_bit <= RST_EXT;
            dir_strap         <= RST_DIR_STRAP;
            captured          <= 1'b0;
        end
        else if (!captured)
        begin
            extended_mode_bit <= ~mode_strap_pin;
            dir_strap         <= direction_strap_pin;
            captured          <= 1'b1;
        end
    end

endmodule

// File: hw/ppdc_top.sv
// Printer port data direction, mode straps and register slave
//
// What this block does
// - Low mode strap at reset sets extended mode
// - Extended mode: direction from control bit five
// - High mode strap clears extended, selects compatible
// - Direction strap fixes direction only in compatible
// - Strap zero drives printer, one reads scanner
// - Eight data lines carry bytes both ways
// - Control bit four lets interrupt follow done
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module ppdc_top
    import ppdc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    input  wire logic        mode_strap_pin,
    input  wire logic        direction_strap_pin,
    input  wire logic [7:0]  port_data_lines_in,
    output logic [7:0]       port_data_lines_out,
    output logic             port_data_lines_oe_n,
    input  wire logic        paper_out_input,
    input  wire logic        printer_done_pulse,
    output logic             printer_interrupt_line_a_out,
    output logic             printer_interrupt_line_a_oe_n,
    output logic             printer_interrupt_line_b_out,
    output logic             printer_interrupt_line_b_oe_n
);

    ppdc_bus_e        state;
    ppdc_bus_e        next_state;
    logic [7:0]       addr_q;
    logic [7:0]       data_reg;
    logic [7:0]       control;
    logic             line_sel;
    logic [EVT_W-1:0] irq_stat;
    logic [EVT_W-1:0] irq_mask;
    logic [7:0]       lines_q;
    logic             paper_q;
    logic             done_q;
    logic             extended_mode_bit;
    logic             dir_strap;
    logic             captured;

    // Strap capture
    ppdc_strap u_strap (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .mode_strap_pin      (mode_strap_pin),
        .direction_strap_pin (direction_strap_pin),
        .extended_mode_bit   (extended_mode_bit),
        .dir_strap           (dir_strap),
        .captured            (captured)
    );

    // Address phase decode and byte-wide write strobes
    wire       accept    = hsel & htrans[1] & hready;
    wire       wr_en     = (state == BUS_WRITE);
    wire       wr_data   = wr_en & (addr_q == OFF_DATA);
    wire       wr_ctrl   = wr_en & (addr_q == OFF_CONTROL);
    wire       wr_mode   = wr_en & (addr_q == OFF_MODE);
    wire       wr_istat  = wr_en & (addr_q == OFF_IRQ_STAT);
    wire       wr_imask  = wr_en & (addr_q == OFF_IRQ_MASK);

    // Current direction: one means input from the peripheral
    wire       dir_in    = extended_mode_bit ? control[CTRL_DIR_BIT]
                                             : dir_strap;
    wire       irq_en    = control[CTRL_IRQ_EN_BIT];

    // Events raised on rising edges of the peripheral inputs
    wire [EVT_W-1:0] evt = {printer_done_pulse & ~done_q,
                            paper_out_input & ~paper_q};

    // Read value selection
    wire [7:0] data_view = dir_in ? lines_q : data_reg;
    wire [7:0] status_v  = {5'h00, dir_in, done_q, paper_q};
    wire [7:0] mode_v    = {extended_mode_bit, 5'h00, dir_strap, line_sel};
    wire [31:0] rd_value =
        (addr_q == OFF_DATA)     ? {24'h000000, data_view} :
        (addr_q == OFF_STATUS)   ? {24'h000000, status_v}  :
        (addr_q == OFF_CONTROL)  ? {24'h000000, control}   :
        (addr_q == OFF_MODE)     ? {24'h000000, mode_v}    :
        (addr_q == OFF_IRQ_STAT) ? {30'h00000000, irq_stat} :
        (addr_q == OFF_IRQ_MASK) ? {30'h00000000, irq_mask} :
                                   32'h00000000;

    // Bus answers: reads take one wait cycle, response always okay
    assign hreadyout = (state != BUS_RWAIT);
    assign hresp     = 1'b0;
    assign irq       = |(irq_stat & irq_mask);

    // Pin drive: enables are active low
    assign port_data_lines_oe_n          = dir_in;
    assign port_data_lines_out           = data_reg;
    assign printer_interrupt_line_a_out  = done_q;
    assign printer_interrupt_line_b_out  = done_q;
    assign printer_interrupt_line_a_oe_n = ~(irq_en & ~line_sel);
    assign printer_interrupt_line_b_oe_n = ~(irq_en & line_sel);

    // Data phase sequencing
    always_comb
    begin
        next_state = BUS_IDLE;
        unique case (state)
            BUS_RWAIT: next_state = BUS_RDONE;
            BUS_IDLE, BUS_WRITE, BUS_RDONE:
            begin
                if (accept)
                    next_state = hwrite ? BUS_WRITE : BUS_RWAIT;
            end
            default: next_state = BUS_IDLE;
        endcase
    end

    // Bus state, held address and read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state  <= BUS_IDLE;
            addr_q <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            state <= next_state;
            if (accept)
                addr_q <= haddr[7:0];
            if (state == BUS_RWAIT)
                hrdata <= rd_value;
        end
    end

    // Software-written registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_reg <= RST_DATA;
            control  <= RST_CONTROL;
            line_sel <= 1'b0;
            irq_mask <= RST_IRQ;
        end
        else
        begin
            if (wr_data)
                data_reg <= hwdata[7:0];
            if (wr_ctrl)
                control <= hwdata[7:0];
            if (wr_mode)
                line_sel <= hwdata[MODE_LINE_SEL_BIT];
            if (wr_imask)
                irq_mask <= hwdata[EVT_W-1:0];
        end
    end

    // Sticky events; a new event beats a write-one clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_stat <= RST_IRQ;
        else
            irq_stat <= (irq_stat & ~(wr_istat ? hwdata[EVT_W-1:0] : 2'h0)) | evt;
    end

    // Input sampling for reads and edge detection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lines_q <= 8'h00;
            paper_q <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            lines_q <= port_data_lines_in;
            paper_q <= paper_out_input;
            done_q  <= printer_done_pulse;
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read_accept;
        accept && !hwrite;
    endsequence

    sequence s_read_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    sequence s_write_accept;
        accept && hwrite;
    endsequence

    // Strap and direction checks
    AST_EXT_FROM_STRAP: assert property (
        $rose(captured) |-> extended_mode_bit == !$past(mode_strap_pin))
        else $error("extended mode does not match mode strap");

    AST_STRAP_HOLDS: assert property (
        captured && $past(captured) |-> $stable(extended_mode_bit) && $stable(dir_strap))
        else $error("strap values changed after capture");

    AST_EXT_DIR: assert property (
        extended_mode_bit |-> port_data_lines_oe_n == control[CTRL_DIR_BIT])
        else $error("extended mode direction not from control bit");

    AST_COMPAT_DIR: assert property (
        !extended_mode_bit |-> port_data_lines_oe_n == dir_strap)
        else $error("compatible mode direction not from strap");

    AST_DRIVE_VALUE: assert property (
        !extended_mode_bit && !dir_strap |->
            !port_data_lines_oe_n && port_data_lines_out == data_reg)
        else $error("compatible output mode does not drive data register");

    AST_STRAP_ONCE: assert property (
        captured |=> captured)
        else $error("strap capture repeated before reset");

    AST_RELEASED_UNTIL_STRAP: assert property (
        !captured |-> port_data_lines_oe_n)
        else $error("lines driven before straps are known");

    // Bus checks
    AST_WRITE_DATA: assert property (
        accept && hwrite && haddr[7:0] == OFF_DATA ##1 hready |=>
            data_reg == $past(hwdata[7:0]))
        else $error("data register write lost");

    AST_READ_LINES: assert property (
        s_read_accept ##0 (haddr[7:0] == OFF_DATA && dir_in) ##1 dir_in ##1 1'b1
            |-> hrdata[7:0] == $past(lines_q))
        else $error("input read does not return sampled lines");

    AST_READ_DATA_OUT: assert property (
        s_read_accept ##0 (haddr[7:0] == OFF_DATA && !dir_in) ##1 !dir_in ##1 1'b1
            |-> hrdata[7:0] == $past(data_reg))
        else $error("output read does not return data register");

    AST_UNMAPPED_READ: assert property (
        s_read_accept ##0 (haddr[7:0] > OFF_IRQ_MASK) ##2 1'b1
            |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");

    AST_READ_TIMING: assert property (
        s_read_accept |=> s_read_answer)
        else $error("read answer not after one wait cycle");

    AST_HRDATA_HOLDS: assert property (
        state != BUS_RWAIT |=> $stable(hrdata))
        else $error("read data changed outside a read");

    AST_WRITE_NO_WAIT: assert property (
        s_write_accept |=> hreadyout)
        else $error("write data phase stalled");

    AST_CTRL_WRITE: assert property (
        wr_ctrl |=> control == $past(hwdata[7:0]))
        else $error("control register write lost");

    // Interrupt checks
    AST_IRQ_FOLLOW: assert property (
        irq_en && !line_sel |->
            !printer_interrupt_line_a_oe_n &&
            printer_interrupt_line_a_out == $past(printer_done_pulse))
        else $error("interrupt line a does not follow done pulse");

    AST_IRQ_FOLLOW_B: assert property (
        irq_en && line_sel |->
            !printer_interrupt_line_b_oe_n &&
            printer_interrupt_line_b_out == $past(printer_done_pulse))
        else $error("interrupt line b does not follow done pulse");

    AST_IRQ_RELEASE: assert property (
        !irq_en |-> printer_interrupt_line_a_oe_n && printer_interrupt_line_b_oe_n)
        else $error("interrupt line driven while disabled");

    AST_EVENT_WINS: assert property (
        paper_out_input && !paper_q |=> irq_stat[EVT_PAPER_OUT])
        else $error("paper-out event lost");

    AST_DONE_EVENT: assert property (
        printer_done_pulse && !done_q |=> irq_stat[EVT_DONE])
        else $error("done event lost");

    AST_EVENT_BEATS_CLEAR: assert property (
        evt[EVT_PAPER_OUT] && wr_istat && hwdata[EVT_PAPER_OUT] |=> irq_stat[EVT_PAPER_OUT])
        else $error("clear won over a new paper-out event");

endmodule

// File: dv/ppdc_printer.sv
// Printer and scanner model on the far side of the port
`timescale 1ns/1ps
module ppdc_printer (
    input  wire logic       lines_oe_n,
    input  wire logic [7:0] lines_out,
    input  wire logic [7:0] scan_byte,
    input  wire logic       paper_empty,
    input  wire logic       done_req,
    output logic      [7:0] lines_in,
    output logic            paper_out,
    output logic            done_pulse
);
    // Wire level: block drives, else the scanner drives its byte
    assign lines_in   = lines_oe_n ? scan_byte : lines_out;
    // Paper-out high only while paper is empty
    assign paper_out  = paper_empty;
    // Done level as the scenario asks
    assign done_pulse = done_req;
endmodule

// File: dv/printer_port_direction_config_tb.sv
// Self-checking bench for the printer port block
`timescale 1ns/1ps
module printer_port_direction_config_tb;
    import ppdc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, irq, oe_n;
    logic        mode_s, dir_s, paper, done, pout, dpul, a_o, a_oe, b_o, b_oe;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q, seed;
    logic [7:0]  scan, lin, lout, v;
    int          errors, check_count;
    int          m_ext, m_dstrap, m_ctrl;
    int          exp_q[$];

    // Design and far-side model
    ppdc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .mode_strap_pin(mode_s), .direction_strap_pin(dir_s), .port_data_lines_in(lin),
        .port_data_lines_out(lout), .port_data_lines_oe_n(oe_n), .paper_out_input(pout),
        .printer_done_pulse(dpul), .printer_interrupt_line_a_out(a_o),
        .printer_interrupt_line_a_oe_n(a_oe), .printer_interrupt_line_b_out(b_o),
        .printer_interrupt_line_b_oe_n(b_oe));
    ppdc_printer u_prn (.lines_oe_n(oe_n), .lines_out(lout), .scan_byte(scan),
        .paper_empty(paper), .done_req(done), .lines_in(lin), .paper_out(pout),
        .done_pulse(dpul));

    // Random source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Rule model: control bit five in extended mode, else the captured strap
    function automatic int m_dir_in();
        return m_ext ? ((m_ctrl >> CTRL_DIR_BIT) & 1) : m_dstrap;
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask

    // One single AHB transfer, waits for hready in both phases
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        logic r;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin @(negedge hclk); r = hrdy; @(posedge hclk); end while (!r);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(negedge hclk); r = hrdy; q = hrdata; @(posedge hclk); end while (!r);
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(n, e, q);
        chk("hresp", 1'b0, hresp);
    endtask

    // Register write that also updates the rule model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        if (a == OFF_CONTROL)
            m_ctrl = int'(d[7:0]);
    endtask

    task automatic rst(input logic m, input logic d);
        @(posedge hclk);
        hresetn <= 1'b0;
        mode_s <= m;
        dir_s <= d;
        m_ext = m ? 0 : 1;
        m_dstrap = int'(d);
        m_ctrl = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask

    // Clock
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Watchdog
    initial
    begin
        #200000;
        errors++;
        close_out();
    end

    initial
    begin
        {hresetn, hsel, hwrite, mode_s, dir_s, paper, done} = 7'h0;
        {htrans, haddr, hwdata, scan} = '0;
        seed = 32'hD6EE;
        errors = 0;
        check_count = 0;
        rst(1'b1, 1'b0);
        rchk("mode", OFF_MODE, 32'h0);
        chk("oe_n", m_dir_in(), oe_n);
        repeat (3)
        begin
            v = 8'(rnd());
            exp_q.push_back(int'(v));
            wr(OFF_DATA, {24'h0, v});
            @(negedge hclk);
            chk("lines", exp_q[0], lout);
            rchk("data", OFF_DATA, exp_q.pop_front());
        end
        wr(OFF_CONTROL, 32'h20);
        @(negedge hclk);
        chk("oe_n", m_dir_in(), oe_n);
        $display("test compat out done");
        rst(1'b1, 1'b1);
        rchk("mode", OFF_MODE, 32'h2);
        chk("oe_n", m_dir_in(), oe_n);
        scan <= 8'(rnd());
        repeat (3) @(posedge hclk);
        rchk("data", OFF_DATA, {24'h0, scan});
        $display("test compat in done");
        rst(1'b0, 1'b1);
        rchk("mode", OFF_MODE, 32'h82);
        chk("oe_n", m_dir_in(), oe_n);
        wr(OFF_CONTROL, 32'h20);
        @(negedge hclk);
        chk("oe_n", m_dir_in(), oe_n);
        rchk("data", OFF_DATA, {24'h0, scan});
        $display("test extended done");
        wr(OFF_CONTROL, 32'h10);
        done <= 1'b1;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk("a_oe", 1'b0, a_oe);
        chk("a_o", 1'b1, a_o);
        chk("b_oe", 1'b1, b_oe);
        wr(OFF_MODE, 32'h1);
        @(negedge hclk);
        chk("b_oe", 1'b0, b_oe);
        chk("b_o", 1'b1, b_o);
        chk("a_oe", 1'b1, a_oe);
        wr(OFF_CONTROL, 32'h0);
        @(negedge hclk);
        chk("b_oe", 1'b1, b_oe);
        wr(OFF_IRQ_MASK, 32'h1);
        paper <= 1'b1;
        rchk("stat", OFF_STATUS, 32'h3);
        rchk("ist", OFF_IRQ_STAT, 32'h3);
        chk("irq", 1'b1, irq);
        wr(OFF_IRQ_STAT, 32'h1);
        @(negedge hclk);
        chk("irq", 1'b0, irq);
        rchk("ist", OFF_IRQ_STAT, 32'h2);
        // New paper-out edge in the same cycle as its clear: the event wins
        paper <= 1'b0;
        repeat (2) @(posedge hclk);
        fork
            wr(OFF_IRQ_STAT, 32'h1);
            begin
                repeat (2) @(posedge hclk);
                paper <= 1'b1;
            end
        join
        rchk("ist", OFF_IRQ_STAT, 32'h3);
        chk("irq", 1'b1, irq);
        rchk("unmap", 8'h40, 32'h0);
        $display("test interrupt done");
        close_out();
    end
endmodule
